// ### hdl/cms_pkg.sv
// Purpose: shared constants and types of the clock mode selector
// Assumes: 32-bit AHB-Lite register access, one word per register
// Notes: clock inputs are synchronous levels sampled on core_clk
package cms_pkg;
    // register byte offsets
    localparam logic [7:0] CMS_CTRL_OFS = 8'h00;
    localparam logic [7:0] CMS_CFG_OFS = 8'h04;
    localparam logic [7:0] CMS_LOOP_OFS = 8'h08;
    localparam logic [7:0] CMS_STAT_OFS = 8'h0C;
    // control field positions
    localparam int CMS_SRC_POS = 6;
    localparam int CMS_REF_DIVIDER_POS = 3;
    localparam int CMS_IREF_POS = 2;
    localparam int CMS_IREN_POS = 1;
    localparam int CMS_ISTP_POS = 0;
    localparam int CMS_BUS_DIVIDER_POS = 6;
    localparam int CMS_LP_POS = 3;
    localparam int CMS_EREN_POS = 2;
    localparam int CMS_ESTP_POS = 0;
    localparam int CMS_LSEL_POS = 6;
    localparam int CMS_VSEL_POS = 0;
    // values after reset
    localparam logic [1:0] CMS_SRC_RST = 2'h0;
    localparam logic [2:0] CMS_REF_DIVIDER_RST = 3'h0;
    localparam logic CMS_IREF_RST = 1'b1;
    localparam logic [1:0] CMS_BUS_DIVIDER_RST = 2'h1;
    localparam logic [3:0] CMS_VSEL_RST = 4'h1;
    // clock source encodings
    localparam logic [1:0] CMS_SRC_FLL = 2'h0;
    localparam logic [1:0] CMS_SRC_INT = 2'h1;
    localparam logic [1:0] CMS_SRC_EXT = 2'h2;
    localparam logic [1:0] CMS_SRC_PLL = 2'h3;
    // loop multipliers
    localparam logic [11:0] CMS_FLL_MULT = 12'h400;
    localparam logic [5:0] CMS_PLL_STEP = 6'h04;
    localparam logic [5:0] CMS_PLL_MAX = 6'h28;
    localparam logic [3:0] CMS_VSEL_TOP = 4'hA;
    localparam int CMS_LOCK_TOL_SHIFT = 4;

    typedef enum logic [8:0] {
        CMS_FEI = 9'h001,
        CMS_FEE = 9'h002,
        CMS_FBI = 9'h004,
        CMS_FBE = 9'h008,
        CMS_PEE = 9'h010,
        CMS_PBE = 9'h020,
        CMS_LOW_POWER_INTERNAL_BYPASS = 9'h040,
        CMS_LOW_POWER_EXTERNAL_BYPASS = 9'h080,
        CMS_STOP = 9'h100
    } cms_mode_t;
endpackage

// ### hdl/cms_clock_mode_selector.sv
// Purpose: clock generator mode logic: mode decode, source switch, loop control
// Assumes: clock inputs are slow synchronous levels; registers on AHB-Lite
// Notes: loops are analog outside; this block enables them and checks lock
//
// The AHB-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
module cms_clock_mode_selector
    import cms_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // system state
    input wire logic stop_req,
    input wire logic background_debug_mode,
    input wire logic ext_ref_valid,
    // clock sources
    input wire logic int_ref_clk,
    input wire logic ext_ref_clk,
    input wire logic fll_clk,
    input wire logic pll_clk,
    input wire logic controlled_oscillator,
    // generated clocks
    output logic main_clock_out,
    output logic bus_clock_out,
    output logic local_debug_clock,
    output logic int_ref_clock_out,
    output logic ext_ref_clock_out,
    // loop control
    output logic fll_enable,
    output logic pll_enable,
    output logic [5:0] pll_multiplier,
    output logic loop_locked,
    output logic [1:0] clock_source_status,
    output logic ref_select_status,
    output cms_mode_t mode
);
    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [1:0] clock_source_select;
        logic [2:0] ref_divider;
        logic ref_select_internal;
        logic int_ref_out_en;
        logic int_ref_stop_en;
        logic [1:0] bus_divider;
        logic low_power_bypass;
        logic ext_ref_out_en;
        logic ext_ref_stop_en;
        logic loop_select;
        logic [3:0] vco_multiplier_sel;
        cms_mode_t mode;
        logic [1:0] clock_source_status;
        logic ref_select_status;
        logic ref_prev;
        logic [6:0] ref_cnt;
        logic loop_prev;
        logic [11:0] loop_cnt;
        logic loop_locked;
        logic main_prev;
        logic [2:0] bus_cnt;
        logic dco_prev;
        logic dco_half;
        logic main_clock_out;
        logic bus_clock_out;
        logic local_debug_clock;
        logic int_ref_clock_out;
        logic ext_ref_clock_out;
        logic fll_enable;
        logic pll_enable;
        logic [5:0] pll_multiplier;
    } cms_state_t;

    cms_state_t st;
    cms_state_t next_st;

    always_comb begin
        logic [1:0] want;
        logic want_ok;
        logic ref_lvl;
        logic ref_rise;
        logic div_edge;
        logic loop_lvl;
        logic [11:0] target;
        logic [11:0] diff;
        logic sel_lvl;
        logic fll_mode;
        logic pll_mode;
        next_st = st;
        want = st.clock_source_status;
        want_ok = 1'b0;
        target = CMS_FLL_MULT;
        diff = 12'h000;

        // ahb-lite: reads answer in the data phase, writes land in the data phase
        next_st.hreadyout = 1'b1;
        next_st.wr_pend = 1'b0;
        if (st.wr_pend) begin
            if (st.wr_addr == CMS_CTRL_OFS) begin
                next_st.clock_source_select = hwdata[CMS_SRC_POS +: 2];
                next_st.ref_divider = hwdata[CMS_REF_DIVIDER_POS +: 3];
                next_st.ref_select_internal = hwdata[CMS_IREF_POS];
                next_st.int_ref_out_en = hwdata[CMS_IREN_POS];
                next_st.int_ref_stop_en = hwdata[CMS_ISTP_POS];
            end else if (st.wr_addr == CMS_CFG_OFS) begin
                next_st.bus_divider = hwdata[CMS_BUS_DIVIDER_POS +: 2];
                next_st.low_power_bypass = hwdata[CMS_LP_POS];
                next_st.ext_ref_out_en = hwdata[CMS_EREN_POS];
                next_st.ext_ref_stop_en = hwdata[CMS_ESTP_POS];
            end else if (st.wr_addr == CMS_LOOP_OFS) begin
                next_st.loop_select = hwdata[CMS_LSEL_POS];
                next_st.vco_multiplier_sel = hwdata[CMS_VSEL_POS +: 4];
            end
        end
        if (hsel && hready && htrans[1]) begin
            next_st.wr_pend = hwrite;
            next_st.wr_addr = haddr;
            next_st.hrdata = 32'h0000_0000;
            if (!hwrite) begin
                if (haddr == CMS_CTRL_OFS) begin
                    next_st.hrdata[CMS_SRC_POS +: 2] = st.clock_source_select;
                    next_st.hrdata[CMS_REF_DIVIDER_POS +: 3] = st.ref_divider;
                    next_st.hrdata[CMS_IREF_POS] = st.ref_select_internal;
                    next_st.hrdata[CMS_IREN_POS] = st.int_ref_out_en;
                    next_st.hrdata[CMS_ISTP_POS] = st.int_ref_stop_en;
                end else if (haddr == CMS_CFG_OFS) begin
                    next_st.hrdata[CMS_BUS_DIVIDER_POS +: 2] = st.bus_divider;
                    next_st.hrdata[CMS_LP_POS] = st.low_power_bypass;
                    next_st.hrdata[CMS_EREN_POS] = st.ext_ref_out_en;
                    next_st.hrdata[CMS_ESTP_POS] = st.ext_ref_stop_en;
                end else if (haddr == CMS_LOOP_OFS) begin
                    next_st.hrdata[CMS_LSEL_POS] = st.loop_select;
                    next_st.hrdata[CMS_VSEL_POS +: 4] = st.vco_multiplier_sel;
                end else if (haddr == CMS_STAT_OFS) begin
                    next_st.hrdata[1:0] = st.clock_source_status;
                    next_st.hrdata[2] = st.ref_select_status;
                    next_st.hrdata[3] = st.loop_locked;
                    next_st.hrdata[4] = st.fll_enable;
                    next_st.hrdata[5] = st.pll_enable;
                    next_st.hrdata[16 +: 9] = st.mode;
                end
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // mode decode; reserved source code 11 keeps the present mode, except that it leaves stop for FEI
        if (stop_req) begin
            next_st.mode = CMS_STOP;
        end else begin
            case (st.clock_source_select)
                2'h0: begin
                    if (st.loop_select) begin
                        next_st.mode = CMS_PEE;
                    end else if (st.ref_select_internal) begin
                        next_st.mode = CMS_FEI;
                    end else begin
                        next_st.mode = CMS_FEE;
                    end
                end
                2'h1: begin
                    if (st.low_power_bypass && !background_debug_mode) begin
                        next_st.mode = CMS_LOW_POWER_INTERNAL_BYPASS;
                    end else begin
                        next_st.mode = CMS_FBI;
                    end
                end
                2'h2: begin
                    if (st.low_power_bypass && !background_debug_mode) begin
                        next_st.mode = CMS_LOW_POWER_EXTERNAL_BYPASS;
                    end else if (st.loop_select) begin
                        next_st.mode = CMS_PBE;
                    end else begin
                        next_st.mode = CMS_FBE;
                    end
                end
                default: begin
                    next_st.mode = (st.mode == CMS_STOP) ? CMS_FEI : st.mode;
                end
            endcase
        end
        // internal bypass keeps whichever loop loop_select names running
        pll_mode = (st.mode == CMS_PEE) || (st.mode == CMS_PBE)
                   || ((st.mode == CMS_FBI) && st.loop_select);
        fll_mode = (st.mode == CMS_FEI) || (st.mode == CMS_FEE)
                   || (st.mode == CMS_FBE) || ((st.mode == CMS_FBI) && !st.loop_select);
        next_st.pll_enable = pll_mode;
        next_st.fll_enable = fll_mode || (pll_mode && background_debug_mode);

        ////////////////////////////////////////////////////////////////////////
        // reference divide by 2^ref_divider and reference switch tracking
        ref_lvl = st.ref_select_status ? int_ref_clk : ext_ref_clk;
        next_st.ref_prev = ref_lvl;
        ref_rise = ref_lvl && !st.ref_prev;
        div_edge = 1'b0;
        if (ref_rise) begin
            if (st.ref_cnt >= 7'((8'h01 << st.ref_divider) - 8'h01)) begin
                next_st.ref_cnt = 7'h00;
                div_edge = 1'b1;
            end else begin
                next_st.ref_cnt = st.ref_cnt + 7'h01;
            end
        end
        if (st.ref_select_internal != st.ref_select_status
            && (st.ref_select_internal || ext_ref_valid)) begin
            next_st.ref_select_status = st.ref_select_internal;
            next_st.ref_prev = 1'b1;
            next_st.ref_cnt = 7'h00;
        end

        // lock check: loop edges per divided reference period vs target
        if (st.vco_multiplier_sel == 4'h0 || st.vco_multiplier_sel > CMS_VSEL_TOP) begin
            next_st.pll_multiplier = CMS_PLL_MAX;
        end else begin
            next_st.pll_multiplier = 6'(st.vco_multiplier_sel * CMS_PLL_STEP);
        end
        loop_lvl = st.pll_enable ? pll_clk : fll_clk;
        next_st.loop_prev = loop_lvl;
        target = st.pll_enable ? {6'h00, st.pll_multiplier} : CMS_FLL_MULT;
        if (loop_lvl && !st.loop_prev && st.loop_cnt != 12'hFFF) begin
            next_st.loop_cnt = st.loop_cnt + 12'h001;
        end
        if (div_edge) begin
            diff = (st.loop_cnt > target) ? st.loop_cnt - target : target - st.loop_cnt;
            next_st.loop_locked = (st.fll_enable || st.pll_enable)
                                  && (diff <= (target >> CMS_LOCK_TOL_SHIFT));
            next_st.loop_cnt = 12'h000;
        end
        // a new reference or loop choice restarts acquisition
        if (next_st.ref_select_status != st.ref_select_status
            || next_st.pll_enable != st.pll_enable || !(st.fll_enable || st.pll_enable)) begin
            next_st.loop_locked = 1'b0;
            next_st.loop_cnt = 12'h000;
        end

        ////////////////////////////////////////////////////////////////////////
        // source switch: only to an available source, and only while both are low
        case (st.clock_source_select)
            2'h0: begin
                want = st.loop_select ? CMS_SRC_PLL : CMS_SRC_FLL;
                want_ok = st.loop_select ? st.pll_enable : st.fll_enable;
            end
            2'h1: begin
                want = CMS_SRC_INT;
                want_ok = 1'b1;
            end
            2'h2: begin
                want = CMS_SRC_EXT;
                want_ok = ext_ref_valid;
            end
            default: begin
                want = st.clock_source_status;
                want_ok = 1'b0;
            end
        endcase
        case (want)
            CMS_SRC_FLL: sel_lvl = fll_clk;
            CMS_SRC_INT: sel_lvl = int_ref_clk;
            CMS_SRC_EXT: sel_lvl = ext_ref_clk;
            default: sel_lvl = pll_clk;
        endcase
        if (want != st.clock_source_status && want_ok && !sel_lvl && !st.main_clock_out) begin
            next_st.clock_source_status = want;
        end
        case (st.clock_source_status)
            CMS_SRC_FLL: sel_lvl = fll_clk;
            CMS_SRC_INT: sel_lvl = int_ref_clk;
            CMS_SRC_EXT: sel_lvl = ext_ref_clk;
            default: sel_lvl = pll_clk;
        endcase
        // a switch in progress holds the output low so no runt pulse escapes
        if (st.mode == CMS_STOP || next_st.clock_source_status != st.clock_source_status) begin
            next_st.main_clock_out = 1'b0;
        end else begin
            next_st.main_clock_out = sel_lvl;
        end

        // bus divider reads the control bits directly, so a change acts at once
        next_st.main_prev = st.main_clock_out;
        if (st.main_clock_out && !st.main_prev) begin
            next_st.bus_cnt = st.bus_cnt + 3'h1;
        end
        if (st.bus_divider == 2'h0) begin
            next_st.bus_clock_out = st.main_clock_out;
        end else begin
            next_st.bus_clock_out = st.bus_cnt[st.bus_divider - 2'h1];
        end

        // debug clock: fll in fll modes, oscillator halved in pll modes under debug
        next_st.dco_prev = controlled_oscillator;
        if (controlled_oscillator && !st.dco_prev) begin
            next_st.dco_half = !st.dco_half;
        end
        if (fll_mode) begin
            next_st.local_debug_clock = fll_clk;
        end else if (pll_mode && background_debug_mode) begin
            next_st.local_debug_clock = st.dco_half;
        end else begin
            next_st.local_debug_clock = 1'b0;
        end

        // reference outputs; in stop each needs its stop enable too
        next_st.int_ref_clock_out = st.int_ref_out_en
            && (st.mode != CMS_STOP || st.int_ref_stop_en) && int_ref_clk;
        next_st.ext_ref_clock_out = st.ext_ref_out_en
            && (st.mode != CMS_STOP || st.ext_ref_stop_en) && ext_ref_clk;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st <= '0;
            st.hreadyout <= 1'b1;
            st.clock_source_select <= CMS_SRC_RST;
            st.ref_divider <= CMS_REF_DIVIDER_RST;
            st.ref_select_internal <= CMS_IREF_RST;
            st.ref_select_status <= CMS_IREF_RST;
            st.bus_divider <= CMS_BUS_DIVIDER_RST;
            st.vco_multiplier_sel <= CMS_VSEL_RST;
            st.pll_multiplier <= CMS_PLL_STEP;
            st.mode <= CMS_FEI;
            st.clock_source_status <= CMS_SRC_FLL;
            st.fll_enable <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign hrdata = st.hrdata;
    assign hreadyout = st.hreadyout;
    assign hresp = 1'b0;
    assign main_clock_out = st.main_clock_out;
    assign bus_clock_out = st.bus_clock_out;
    assign local_debug_clock = st.local_debug_clock;
    assign int_ref_clock_out = st.int_ref_clock_out;
    assign ext_ref_clock_out = st.ext_ref_clock_out;
    assign fll_enable = st.fll_enable;
    assign pll_enable = st.pll_enable;
    assign pll_multiplier = st.pll_multiplier;
    assign loop_locked = st.loop_locked;
    assign clock_source_status = st.clock_source_status;
    assign ref_select_status = st.ref_select_status;
    assign mode = st.mode;
endmodule // cms_clock_mode_selector

// ### testbench/cms_ref_src.sv
// Purpose: stand-in for the external oscillator and the loop clock sources
// Assumes: every source is a level sampled on core_clk, periods of 4 cycles or more
// Notes: the external clock stands still and reads not valid while switched off
`timescale 1ns/1ps
module cms_ref_src #(
    parameter int START = 40
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // oscillator control
    input wire logic osc_on,
    // sources
    output logic int_ref_clk,
    output logic ext_ref_clk,
    output logic fll_clk,
    output logic pll_clk,
    output logic controlled_oscillator,
    output logic ext_ref_valid
);
    logic [3:0] cnt;
    logic [3:0] ecnt;
    int up;
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk) begin
        cnt <= sys_rst ? 4'h0 : cnt + 4'h1;
    end
    // a slow start-up lets the bench see a request for a clock not yet usable
    always_ff @(posedge core_clk) begin
        if (sys_rst || !osc_on) begin
            ecnt <= 4'h0;
            up <= 0;
            ext_ref_clk <= 1'b0;
            ext_ref_valid <= 1'b0;
        end else begin
            ecnt <= (ecnt == 4'h4) ? 4'h0 : ecnt + 4'h1;
            ext_ref_clk <= (ecnt == 4'h4) ? !ext_ref_clk : ext_ref_clk;
            up <= (up < START) ? up + 1 : up;
            ext_ref_valid <= (up >= START);
        end
    end
    assign int_ref_clk = cnt[2];
    assign fll_clk = cnt[1];
    assign pll_clk = cnt[1] ^ cnt[2];
    assign controlled_oscillator = cnt[3];
endmodule // cms_ref_src

// ### testbench/cms_clock_mode_selector_sva.sv
// Purpose: port-level checks of the clock mode selector
// Assumes: one clock domain, synchronous active-high reset
// Notes: lock accuracy is not judged here
`timescale 1ns/1ps
module cms_clock_mode_selector_sva
    import cms_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // watched ports
    input wire logic stop_req,
    input wire logic background_debug_mode,
    input wire logic fll_clk,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic main_clock_out,
    input wire logic local_debug_clock,
    input wire logic fll_enable,
    input wire logic pll_enable,
    input wire logic [5:0] pll_multiplier,
    input wire logic [1:0] clock_source_status,
    input wire logic ref_select_status,
    input wire cms_mode_t mode
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic fm;
    logic pm;
    logic lm;
    assign fm = mode inside {CMS_FEI, CMS_FEE, CMS_FBE};
    assign pm = mode inside {CMS_PEE, CMS_PBE};
    assign lm = mode inside {CMS_LOW_POWER_INTERNAL_BYPASS, CMS_LOW_POWER_EXTERNAL_BYPASS};
    ////////////////////////////////////////////////////////////////////////
    reset_state_a: assert property ($fell(sys_rst) |-> mode == CMS_FEI
        && clock_source_status == CMS_SRC_FLL && ref_select_status) else $error("bad reset state");
    stop_mode_a: assert property (stop_req |=> mode == CMS_STOP) else $error("no stop");
    stop_quiet_a: assert property ((mode == CMS_STOP)[*3] |->
        !fll_enable && !pll_enable && !main_clock_out) else $error("clocks live in stop");
    fll_debug_a: assert property (fm[*3] |-> local_debug_clock == $past(fll_clk))
        else $error("debug clock not from fll");
    pll_off_a: assert property (fm[*3] |-> !pll_enable) else $error("pll on");
    pll_nodbg_a: assert property ((pm && !background_debug_mode)[*3] |->
        !fll_enable && !local_debug_clock) else $error("fll on without debug");
    blp_quiet_a: assert property (lm[*3] |->
        !fll_enable && !pll_enable && !local_debug_clock) else $error("loops on in low power");
    mult_range_a: assert property (pll_multiplier inside {[6'h04:6'h28]}
        && pll_multiplier[1:0] == 2'h0) else $error("bad multiplier");
    src_switch_a: assert property ($changed(clock_source_status) |-> !main_clock_out)
        else $error("glitch on switch");
    bus_okay_a: assert property (hreadyout && !hresp) else $error("bus not okay");
    cover property (mode == CMS_PEE);
    cover property (mode == CMS_LOW_POWER_EXTERNAL_BYPASS);
    cover property (mode == CMS_STOP);
    cover property (clock_source_status == CMS_SRC_PLL);
endmodule // cms_clock_mode_selector_sva
bind cms_clock_mode_selector cms_clock_mode_selector_sva cms_clock_mode_selector_sva_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .stop_req(stop_req), .fll_clk(fll_clk),
    .background_debug_mode(background_debug_mode), .hreadyout(hreadyout), .hresp(hresp),
    .main_clock_out(main_clock_out), .local_debug_clock(local_debug_clock),
    .fll_enable(fll_enable), .pll_enable(pll_enable), .pll_multiplier(pll_multiplier),
    .clock_source_status(clock_source_status), .ref_select_status(ref_select_status),
    .mode(mode));

// ### testbench/cms_clock_mode_selector_tb.sv
// Purpose: self-checking bench of the clock mode selector
// Assumes: one AHB-Lite master, reads checked from a queue of notes
// Notes: output clocks are judged by counting their edges over a window
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module cms_clock_mode_selector_tb
    import cms_pkg::*;
;
    typedef struct packed {logic [31:0] e; logic [31:0] m;} cms_note_t;
    logic core_clk = 0, sys_rst = 1, hsel = 0, hwrite = 0, stop_req = 0, osc_on = 0, rd_ph = 0;
    logic background_debug_mode = 0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, hrdata, seed = 32'h000156D3;
    logic hreadyout, hresp, int_ref_clk, ext_ref_clk, fll_clk, pll_clk, controlled_oscillator;
    logic ext_ref_valid, main_clock_out, bus_clock_out, local_debug_clock, int_ref_clock_out;
    logic ext_ref_clock_out, fll_enable, pll_enable, loop_locked, ref_select_status;
    logic [5:0] pll_multiplier;
    logic [1:0] clock_source_status;
    logic [2:0] prv = 3'h0;
    cms_mode_t mode;
    cms_note_t notes[$];
    int n_mismatch = 0, comparisons = 0, cyc = 0, ci = 0, ce = 0, cb = 0;
    cms_ref_src #(.START(40)) cms_ref_src_i (.core_clk(core_clk), .sys_rst(sys_rst),
        .osc_on(osc_on), .int_ref_clk(int_ref_clk), .ext_ref_clk(ext_ref_clk),
        .fll_clk(fll_clk), .pll_clk(pll_clk), .controlled_oscillator(controlled_oscillator),
        .ext_ref_valid(ext_ref_valid));
    cms_clock_mode_selector cms_clock_mode_selector_i (.core_clk(core_clk), .sys_rst(sys_rst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .stop_req(stop_req), .background_debug_mode(background_debug_mode),
        .ext_ref_valid(ext_ref_valid), .int_ref_clk(int_ref_clk), .ext_ref_clk(ext_ref_clk),
        .fll_clk(fll_clk), .pll_clk(pll_clk), .controlled_oscillator(controlled_oscillator),
        .main_clock_out(main_clock_out), .bus_clock_out(bus_clock_out),
        .local_debug_clock(local_debug_clock), .int_ref_clock_out(int_ref_clock_out),
        .ext_ref_clock_out(ext_ref_clock_out), .fll_enable(fll_enable),
        .pll_enable(pll_enable), .pll_multiplier(pll_multiplier), .loop_locked(loop_locked),
        .clock_source_status(clock_source_status), .ref_select_status(ref_select_status),
        .mode(mode));
    always #2.5 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task close_out;
        if (n_mismatch == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // holds each phase until hready is seen
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        htrans <= 2'h0;
        hwdata <= d;
        rd_ph <= !wr;
        if (!wr) notes.push_back({d & m, m});
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        rd_ph <= 1'b0;
    endtask
    task stat(cms_mode_t md, logic [1:0] src, logic rs, logic [1:0] en, logic [1:0] em);
        bus(1'b0, CMS_STAT_OFS, {7'h0, md, 10'h0, en, 1'b0, rs, src}, {16'h01FF, 10'h0, em, 4'h7});
    endtask
    always @(posedge core_clk) begin
        cms_note_t n;
        if (rd_ph && hreadyout === 1'b1) begin
            n = notes.pop_front();
            `CHK(hrdata & n.m, n.e)
        end
        ci += int'(prv[0] != int_ref_clock_out);
        ce += int'(prv[1] != ext_ref_clock_out);
        cb += int'(!prv[2] && bus_clock_out);
        prv <= {bus_clock_out, ext_ref_clock_out, int_ref_clock_out};
        cyc++;
        if (cyc > 40000) begin
            n_mismatch++;
            close_out();
        end
    end
    initial begin
        idle(10);
        sys_rst <= 1'b0;
        bus(1'b0, CMS_CTRL_OFS, 32'h04, 32'hFF);
        bus(1'b0, CMS_CFG_OFS, 32'h40, 32'hCD);
        bus(1'b0, CMS_LOOP_OFS, 32'h01, 32'h4F);
        repeat (4) begin
            seed = lfsr(seed);
            bus(1'b1, 8'h10, seed, 32'h0);
            bus(1'b1, CMS_STAT_OFS, seed, 32'h0);
        end
        bus(1'b0, 8'h10, 32'h0, 32'hFFFFFFFF);
        stat(CMS_FEI, CMS_SRC_FLL, 1'b1, 2'b01, 2'b11);
        for (int c = 1; c < 16; c++) begin
            bus(1'b1, CMS_LOOP_OFS, 32'(c), 32'h0);
            idle(3);
            `CHK(pll_multiplier, (c > 10) ? CMS_PLL_MAX : 6'(c * 4))
        end
        bus(1'b1, CMS_LOOP_OFS, 32'h01, 32'h0);
        bus(1'b1, CMS_CTRL_OFS, 32'h44, 32'h0);
        idle(30);
        stat(CMS_FBI, CMS_SRC_INT, 1'b1, 2'b01, 2'b11);
        for (int b = 0; b < 4; b++) begin
            bus(1'b1, CMS_CFG_OFS, 32'(b << 6), 32'h0);
            idle(8);
            cb = 0;
            idle(512);
            `CHK((cb >= (64 >> b) - 1) && (cb <= (64 >> b) + 1), 1'b1)
        end
        bus(1'b1, CMS_CFG_OFS, 32'h40, 32'h0);
        bus(1'b1, CMS_CTRL_OFS, 32'h98, 32'h0);
        idle(30);
        stat(CMS_FBE, CMS_SRC_INT, 1'b1, 2'b00, 2'b00);
        osc_on <= 1'b1;
        idle(100);
        stat(CMS_FBE, CMS_SRC_EXT, 1'b0, 2'b01, 2'b11);
        idle(20000);
        stop_req <= 1'b1;
        idle(10);
        stop_req <= 1'b0;
        bus(1'b1, CMS_CTRL_OFS, 32'h18, 32'h0);
        idle(30);
        stat(CMS_FEE, CMS_SRC_FLL, 1'b0, 2'b01, 2'b11);
        bus(1'b1, CMS_LOOP_OFS, 32'h42, 32'h0);
        idle(30);
        stat(CMS_PEE, CMS_SRC_PLL, 1'b0, 2'b10, 2'b11);
        background_debug_mode <= 1'b1;
        bus(1'b1, CMS_CTRL_OFS, 32'h98, 32'h0);
        idle(30);
        stat(CMS_PBE, CMS_SRC_EXT, 1'b0, 2'b11, 2'b11);
        background_debug_mode <= 1'b0;
        bus(1'b1, CMS_CFG_OFS, 32'h48, 32'h0);
        idle(10);
        stat(CMS_LOW_POWER_EXTERNAL_BYPASS, CMS_SRC_EXT, 1'b0, 2'b00, 2'b11);
        background_debug_mode <= 1'b1;
        idle(10);
        stat(CMS_PBE, CMS_SRC_EXT, 1'b0, 2'b11, 2'b11);
        background_debug_mode <= 1'b0;
        bus(1'b1, CMS_CTRL_OFS, 32'h44, 32'h0);
        idle(30);
        stat(CMS_LOW_POWER_INTERNAL_BYPASS, CMS_SRC_INT, 1'b1, 2'b00, 2'b11);
        background_debug_mode <= 1'b1;
        idle(10);
        stat(CMS_FBI, CMS_SRC_INT, 1'b1, 2'b00, 2'b00);
        background_debug_mode <= 1'b0;
        bus(1'b1, CMS_LOOP_OFS, 32'h01, 32'h0);
        bus(1'b1, CMS_CFG_OFS, 32'h44, 32'h0);
        bus(1'b1, CMS_CTRL_OFS, 32'h07, 32'h0);
        idle(40);
        stop_req <= 1'b1;
        idle(10);
        ci = 0;
        ce = 0;
        idle(40);
        `CHK(ci > 0, 1'b1)
        `CHK(ce, 0)
        stat(CMS_STOP, CMS_SRC_FLL, 1'b1, 2'b00, 2'b11);
        bus(1'b1, CMS_CFG_OFS, 32'h45, 32'h0);
        bus(1'b1, CMS_CTRL_OFS, 32'h06, 32'h0);
        idle(10);
        ci = 0;
        ce = 0;
        idle(40);
        `CHK(ci, 0)
        `CHK(ce > 0, 1'b1)
        stop_req <= 1'b0;
        idle(30);
        stat(CMS_FEI, CMS_SRC_FLL, 1'b1, 2'b01, 2'b11);
        close_out();
    end
endmodule // cms_clock_mode_selector_tb
